// [rtl/fox_flash_ctrl.sv]
/*
 Command-level control of a serial NOR flash: one-time area program with
 locking, and entry, stay and exit of direct_execute_mode.
 Assumes the host drives chip select, serial clock and data lines from its
 own clock; all pins are synchronised and the serial clock edges are found
 by sampling, so the serial clock must stay well below a quarter of clk.
*/
// Behaviour
// RULE1: one-time program takes at most 64 data bytes plus the control byte
// RULE2: write-in-progress reads 1 during program, 0 when it finishes
// RULE3: write enable latch cleared at program end, pass or fail
// RULE4: program timeout clears write enable latch and sets program-fail flag
// RULE5: no chip select rise after whole byte: no program, no flags, latch stays
// RULE6: control byte 64 bit 0 at 0 locks the area forever
// RULE7: locked area: program ignored, latch kept, flag bits 1 and 4 set
// RULE8: host arms direct_execute_mode by writing config bit 3 to 0
// RULE9: confirm bit 0 in next quick read enters direct_execute_mode
// RULE10: in direct_execute_mode each transaction is address only
// RULE11: confirm bit 1 exits mode and restores config bit 3 to 1
// RULE12: basic variant enters mode on confirm 0 without arming
// RULE13: boot setting in bits 11:9 starts device in direct_execute_mode
// RULE14: confirm bit sampled on serial_line_zero at first dummy clock
// RULE15: other data lines ignored during first dummy clock
// RULE16: reset pin low pulse while deselected restores power-up state
// RULE17: host forces exit with line zero high for 7, 13 or 25 clocks
// RULE18: forced exit only leaves the mode, program keeps running
// RULE19: host follows forced exit with reset arm and reset execute
// RULE20: reset arm 66h, deselect gap, then 99h resets on chip select rise
// RULE21: program ignored without flags unless write enable latch is set
// RULE22: outside direct_execute_mode every transaction starts with a command
`timescale 1ns/100ps
`default_nettype none
module fox_flash_ctrl #(
    parameter int PROG_TIMEOUT_CYC = fox_pkg::PROG_TIMEOUT_DEF
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // serial link pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic [3:0] dqIn,
    input wire logic rstPinN,
    // configuration straps and array ready
    input wire fox_pkg::fox_proto_t protocolSel,
    input wire logic basicXip,
    input wire logic [2:0] nvcrXipMode,
    input wire logic resetPinEnable,
    input wire logic arrayReady,
    // status
    output logic [7:0] statusReg,
    output logic [7:0] flagStatus,
    output logic xipActive,
    output logic vcrXipEnableN,
    output logic otpLocked,
    output logic softReset,
    // read request towards the array
    output logic readStart,
    output logic [23:0] readAddr
);
    import fox_pkg::*;

    localparam int TW = $clog2(PROG_TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TMO_LAST = TW'(PROG_TIMEOUT_CYC - 1);
    localparam logic [7:0] GAP_CYC = 8'(DESELECT_GAP_CYC);
    localparam logic [5:0] DUMMY_LAST = 6'(DUMMY_CLKS - 1);
    localparam logic [6:0] OTP_COUNT = 7'(OTP_BYTES);

    logic [6:0] pinSync;
    logic rstPinS, csNS, sclkS;
    logic [3:0] dqS;
    logic sclkPrev, csPrev, rstPinPrev;
    logic sclkRise, csFall, csRise;
    fox_phase_t phase;
    logic [5:0] bitCnt, step, nextCnt;
    logic [31:0] shift, next_shift;
    logic [7:0] cmd, dataByte, gapCnt;
    logic [23:0] addr;
    logic [6:0] byteCount;
    logic wel, armed, gapOk, bootPending, fsProgFail, fsProtErr;
    fox_prog_t pg;
    logic [6:0] idx, len, base, room, calcLen;
    logic [TW-1:0] tmo;
    logic busy, firstDummy, cmdDone, progEnd, stageWe, tmoHit;
    logic evWren, evWrdi, evRstArm, evRstExec, evClrFlags, evVcrWrite;
    logic evProgReq, evProgStart, evProgLocked, evProgDone, evProgFail, evPinReset, evSoftReset;

    fox_mem_if #(.AW(7), .DW(8)) stageIf ();
    fox_mem_if #(.AW(7), .DW(8)) otpIf ();

    // pins cross into clk before anything looks at them
    fox_pin_sync #(.WIDTH(7), .RESET_VAL(7'h7F)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pinIn({rstPinN, csN, sclk, dqIn}),
        .pinSync(pinSync)
    );
    assign {rstPinS, csNS, sclkS, dqS} = pinSync;

    // bytes of one program command wait here until chip select rises
    fox_byte_mem #(.DEPTH(OTP_BYTES), .AW(7), .INIT(OTP_ERASED)) u_stage (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .mp(stageIf.mem)
    );

    // the one-time area itself, control byte at the top
    fox_byte_mem #(.DEPTH(OTP_BYTES), .AW(7), .INIT(OTP_ERASED)) u_otp (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .mp(otpIf.mem)
    );

    function automatic logic isFastRead(input logic [7:0] c);
        return (c == CMD_FAST_READ) || (c == CMD_DOUT_READ) || (c == CMD_QOUT_READ) ||
               (c == CMD_DIO_READ) || (c == CMD_QIO_READ);
    endfunction

    // edge history of the synchronised pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkPrev <= 1'b1;
            csPrev <= 1'b1;
            rstPinPrev <= 1'b1;
        end else if (ce) begin
            sclkPrev <= sclkS;
            csPrev <= csNS;
            rstPinPrev <= rstPinS;
        end
    end

    assign sclkRise = sclkS & ~sclkPrev & ~csNS;
    assign csFall = ~csNS & csPrev;
    assign csRise = csNS & ~csPrev;

    // shift width follows the active protocol
    always_comb begin
        case (protocolSel)
            PROTO_DUAL: begin
                step = 6'h02;
                next_shift = {shift[29:0], dqS[1:0]};
            end
            PROTO_QUAD: begin
                step = 6'h04;
                next_shift = {shift[27:0], dqS};
            end
            default: begin
                step = 6'h01;
                next_shift = {shift[30:0], dqS[0]};
            end
        endcase
    end
    assign nextCnt = bitCnt + step;

    // serial front end: command, address, dummy and data phases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= PH_IGNORE;
            bitCnt <= 6'h00;
            shift <= 32'h00000000;
            cmd <= 8'h00;
            addr <= 24'h000000;
            dataByte <= 8'h00;
            byteCount <= 7'h00;
        end else if (ce) begin
            if (csFall) begin
                phase <= xipActive ? PH_ADDR : PH_CMD; // RULE10 RULE22
                cmd <= xipActive ? CMD_FAST_READ : 8'h00; // RULE10
                bitCnt <= 6'h00;
                byteCount <= 7'h00;
                shift <= 32'h00000000;
            end else if (sclkRise) begin
                shift <= next_shift;
                case (phase)
                    PH_CMD: begin
                        if (nextCnt == 6'h08) begin
                            cmd <= next_shift[7:0];
                            bitCnt <= 6'h00;
                            if (isFastRead(next_shift[7:0]) || next_shift[7:0] == CMD_PROG_OTP) begin
                                phase <= PH_ADDR;
                            end else if (next_shift[7:0] == CMD_WR_VCR) begin
                                phase <= PH_DATA;
                            end else begin
                                phase <= PH_IGNORE;
                            end
                        end else begin
                            bitCnt <= nextCnt;
                        end
                    end
                    PH_ADDR: begin
                        if (nextCnt == 6'h18) begin
                            addr <= next_shift[23:0];
                            bitCnt <= 6'h00;
                            phase <= (cmd == CMD_PROG_OTP) ? PH_DATA : PH_DUMMY;
                        end else begin
                            bitCnt <= nextCnt;
                        end
                    end
                    PH_DUMMY: begin
                        // dummy phase counts clocks, not bits
                        if (bitCnt == DUMMY_LAST) begin
                            bitCnt <= 6'h00;
                            phase <= PH_DATA;
                        end else begin
                            bitCnt <= bitCnt + 6'h01;
                        end
                    end
                    PH_DATA: begin
                        if (nextCnt == 6'h08) begin
                            bitCnt <= 6'h00;
                            dataByte <= next_shift[7:0];
                            if (byteCount != 7'h7F) begin
                                byteCount <= byteCount + 7'h01;
                            end
                        end else begin
                            bitCnt <= nextCnt;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read request to the array once the dummy clocks are over
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readStart <= 1'b0;
            readAddr <= 24'h000000;
        end else if (ce) begin
            readStart <= sclkRise && !csFall && phase == PH_DUMMY && bitCnt == DUMMY_LAST;
            readAddr <= addr;
        end
    end

    // only line zero is looked at in the first dummy clock
    assign firstDummy = sclkRise && !csFall && phase == PH_DUMMY && bitCnt == 6'h00; // RULE14 RULE15

    // chip select rise events
    assign cmdDone = csRise && phase == PH_IGNORE;
    assign evWren = cmdDone && cmd == CMD_WREN;
    assign evWrdi = cmdDone && cmd == CMD_WRDI;
    assign evRstArm = cmdDone && cmd == CMD_RST_ARM;
    assign evRstExec = cmdDone && cmd == CMD_RST_EXEC && armed && gapOk; // RULE20
    assign evClrFlags = cmdDone && cmd == CMD_CLR_FLAGS;
    assign evVcrWrite = csRise && cmd == CMD_WR_VCR && phase == PH_DATA && bitCnt == 6'h00 && byteCount != 7'h00;
    // a rise mid-byte or before any data byte leaves everything untouched
    assign progEnd = csRise && cmd == CMD_PROG_OTP && phase == PH_DATA && bitCnt == 6'h00 &&
                     byteCount != 7'h00; // RULE5
    assign evProgReq = progEnd && wel && !busy; // RULE21
    assign evProgLocked = evProgReq && otpLocked; // RULE7
    assign evProgStart = evProgReq && !otpLocked;
    assign evPinReset = resetPinEnable && csNS && rstPinPrev && !rstPinS; // RULE16
    assign evSoftReset = evRstExec || evPinReset;

    // reset arm must be followed by execute after a long enough deselect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
            gapOk <= 1'b0;
            gapCnt <= 8'h00;
        end else if (ce) begin
            if (csNS) begin
                gapCnt <= (gapCnt == GAP_CYC) ? gapCnt : gapCnt + 8'h01;
            end else begin
                gapCnt <= 8'h00;
            end
            if (csFall) begin
                gapOk <= (gapCnt == GAP_CYC); // RULE20
            end
            if (evSoftReset) begin
                armed <= 1'b0;
            end else if (csRise) begin
                armed <= evRstArm; // RULE20
            end
        end
    end

    // registered pulse so the rest of the chip sees the power-on state request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softReset <= 1'b0;
        end else if (ce) begin
            softReset <= evSoftReset;
        end
    end

    // direct_execute_mode and the volatile arming bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xipActive <= 1'b0;
            vcrXipEnableN <= 1'b1;
            bootPending <= 1'b1;
        end else if (ce) begin
            if (evSoftReset) begin
                xipActive <= 1'b0; // RULE16
                vcrXipEnableN <= 1'b1;
                bootPending <= 1'b1;
            end else if (bootPending) begin
                // boot strap is caught after reset release, confirm taken as 0
                xipActive <= (nvcrXipMode != NVCR_XIP_OFF); // RULE13
                vcrXipEnableN <= (nvcrXipMode == NVCR_XIP_OFF);
                bootPending <= 1'b0;
            end else if (firstDummy) begin
                if (xipActive && dqS[0]) begin
                    // forced-exit clocks land here too; program state is untouched
                    xipActive <= 1'b0; // RULE11 RULE17 RULE18
                    vcrXipEnableN <= 1'b1; // RULE11
                end else if (!xipActive && !dqS[0] && (!vcrXipEnableN || basicXip)) begin
                    xipActive <= 1'b1; // RULE9 RULE12
                end
            end else if (evVcrWrite) begin
                vcrXipEnableN <= dataByte[VCR_XIP_BIT]; // RULE8
            end
        end
    end

    // write enable latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wel <= 1'b0;
        end else if (ce) begin
            if (evSoftReset || evProgDone || evProgFail) begin
                wel <= 1'b0; // RULE3 RULE4
            end else if (evWren) begin
                wel <= 1'b1;
            end else if (evWrdi) begin
                wel <= 1'b0;
            end
        end
    end

    // capture bytes while the command streams in; extra bytes are dropped
    assign stageWe = sclkRise && !csFall && phase == PH_DATA && nextCnt == 6'h08 &&
                     cmd == CMD_PROG_OTP && byteCount < OTP_COUNT && !busy; // RULE1
    assign stageIf.we = stageWe;
    assign stageIf.waddr = byteCount;
    assign stageIf.wdata = next_shift[7:0];
    assign stageIf.raddr = idx;

    // bytes that fit between the start address and the control byte
    assign room = (addr[23:7] == 17'h00000 && addr[6:0] <= OTP_CTRL_ADDR) ? OTP_COUNT - addr[6:0] : 7'h00;
    assign calcLen = (byteCount < room) ? byteCount : room; // RULE1

    // program engine: read old byte, merge, write back
    assign busy = (pg != PG_IDLE);
    assign tmoHit = (tmo >= TMO_LAST);
    assign evProgDone = (pg == PG_DONE);
    assign evProgFail = (pg == PG_MERGE) && tmoHit && !arrayReady;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg <= PG_IDLE;
            idx <= 7'h00;
            len <= 7'h00;
            base <= 7'h00;
            tmo <= '0;
        end else if (ce) begin
            if (evSoftReset) begin
                pg <= PG_IDLE;
            end else begin
                case (pg)
                    PG_IDLE: begin
                        if (evProgStart) begin
                            base <= addr[6:0];
                            len <= calcLen;
                            idx <= 7'h00;
                            tmo <= '0;
                            pg <= PG_READ;
                        end
                    end
                    PG_READ: begin
                        tmo <= tmo + 1'b1;
                        pg <= (idx == len) ? PG_DONE : PG_MERGE;
                    end
                    PG_MERGE: begin
                        tmo <= tmo + 1'b1;
                        if (arrayReady) begin
                            idx <= idx + 7'h01;
                            pg <= PG_READ;
                        end else if (tmoHit) begin
                            pg <= PG_IDLE; // RULE4
                        end
                    end
                    default: begin
                        pg <= PG_IDLE; // RULE2
                    end
                endcase
            end
        end
    end

    // programming only clears bits, so a zero lock bit stays zero
    assign otpIf.raddr = base + idx;
    assign otpIf.waddr = base + idx;
    assign otpIf.wdata = otpIf.rdata & stageIf.rdata; // RULE6
    assign otpIf.we = (pg == PG_MERGE) && arrayReady && !evSoftReset;

    // lock state mirrors control byte bit 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otpLocked <= 1'b0;
        end else if (ce) begin
            if (otpIf.we && otpIf.waddr == OTP_CTRL_ADDR && !otpIf.wdata[OTP_LOCK_BIT]) begin
                otpLocked <= 1'b1; // RULE6
            end
        end
    end

    // error flags; a new error wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fsProgFail <= 1'b0;
            fsProtErr <= 1'b0;
        end else if (ce) begin
            if (evSoftReset) begin
                fsProgFail <= 1'b0;
                fsProtErr <= 1'b0;
            end else begin
                fsProgFail <= evProgFail || evProgLocked || (fsProgFail && !evClrFlags); // RULE4 RULE7
                fsProtErr <= evProgLocked || (fsProtErr && !evClrFlags); // RULE7
            end
        end
    end

    // status views built from state flops
    always_comb begin
        statusReg = 8'h00;
        statusReg[SR_WIP] = busy; // RULE2
        statusReg[SR_WEL] = wel;
        flagStatus = 8'h00;
        flagStatus[FS_PROT] = fsProtErr;
        flagStatus[FS_PROG_FAIL] = fsProgFail;
    end
endmodule
`default_nettype wire

// [rtl/fox_pkg.sv]
/*
 Shared constants and types for the serial flash one-time area program
 and direct-execute control block.
 Assumes a 200 MHz core clock; all pin timing is counted in its cycles.
*/
package fox_pkg;
    // core clock and link timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int DESELECT_GAP_TIME_NS = 50;
    localparam int DESELECT_GAP_CYC = (DESELECT_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIMEOUT_DEF = 20000;
    localparam int DUMMY_CLKS = 8;

    // one-time area layout
    localparam int OTP_BYTES = 65;
    localparam logic [6:0] OTP_CTRL_ADDR = 7'h40;
    localparam int OTP_LOCK_BIT = 0;
    localparam logic [7:0] OTP_ERASED = 8'hFF;

    // command codes
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RST_ARM = 8'h66;
    localparam logic [7:0] CMD_RST_EXEC = 8'h99;
    localparam logic [7:0] CMD_PROG_OTP = 8'h42;
    localparam logic [7:0] CMD_WR_VCR = 8'h81;
    localparam logic [7:0] CMD_CLR_FLAGS = 8'h50;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_DOUT_READ = 8'h3B;
    localparam logic [7:0] CMD_QOUT_READ = 8'h6B;
    localparam logic [7:0] CMD_DIO_READ = 8'hBB;
    localparam logic [7:0] CMD_QIO_READ = 8'hEB;

    // register bit positions and reset values
    localparam int SR_WIP = 0;
    localparam int SR_WEL = 1;
    localparam int FS_PROT = 1;
    localparam int FS_PROG_FAIL = 4;
    localparam int VCR_XIP_BIT = 3;
    localparam logic [2:0] NVCR_XIP_OFF = 3'h7;

    typedef enum logic [1:0] {PROTO_EXT = 2'h0, PROTO_DUAL = 2'h1, PROTO_QUAD = 2'h2} fox_proto_t;
    typedef enum logic [2:0] {
        PH_CMD = 3'h0, PH_ADDR = 3'h1, PH_DUMMY = 3'h3, PH_DATA = 3'h2, PH_IGNORE = 3'h6
    } fox_phase_t;
    typedef enum logic [1:0] {PG_IDLE = 2'h0, PG_READ = 2'h1, PG_MERGE = 2'h3, PG_DONE = 2'h2} fox_prog_t;
endpackage

// [rtl/fox_mem_if.sv]
/*
 Byte memory access bundle between the controller and its memories.
 Assumes one write port and one registered read port per memory.
*/
`timescale 1ns/100ps
`default_nettype none
interface fox_mem_if #(parameter int AW = 7, parameter int DW = 8);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [rtl/fox_pin_sync.sv]
/*
 Two-flop synchroniser for pins arriving from outside the core clock.
 Assumes each bit is an independent level; no bus coherence is implied.
*/
`timescale 1ns/100ps
`default_nettype none
module fox_pin_sync #(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // pins and synchronised copies
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;
        // first flop feeds only the second one
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta <= RESET_VAL[i];
                pinSync[i] <= RESET_VAL[i];
            end else if (ce) begin
                meta <= pinIn[i];
                pinSync[i] <= meta;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/fox_byte_mem.sv]
/*
 Small byte memory with registered read data and reset to a fill value.
 Assumes writes beyond DEPTH are dropped by the caller or here.
*/
`timescale 1ns/100ps
`default_nettype none
module fox_byte_mem #(
    parameter int DEPTH = 65,
    parameter int AW = 7,
    parameter logic [7:0] INIT = 8'hFF
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // access port
    fox_mem_if.mem mp
);
    logic [7:0] store [DEPTH];

    // reset fill keeps never-written bytes at the erased value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= INIT;
            end
            mp.rdata <= INIT;
        end else if (ce) begin
            if (mp.we && (int'(mp.waddr) < DEPTH)) begin
                store[mp.waddr] <= mp.wdata;
            end
            mp.rdata <= (int'(mp.raddr) < DEPTH) ? store[mp.raddr] : INIT;
        end
    end
endmodule
`default_nettype wire

// [dv/fox_flash_ctrl_asserts.sv]
/* port checker for fox_flash_ctrl.
   bound from the bench top; sees top ports only. */
`timescale 1ns/100ps
`default_nettype none
module fox_flash_ctrl_asserts (
    // clocking and straps
    input wire logic clk,
    input wire logic rst,
    input wire logic basicXip,
    input wire logic [2:0] nvcrXipMode,
    // status seen
    input wire logic [7:0] statusReg,
    input wire logic [7:0] flagStatus,
    input wire logic xipActive,
    input wire logic vcrXipEnableN,
    input wire logic otpLocked,
    input wire logic softReset
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_lock_stays: assert property (!$fell(otpLocked)) else $error("lock cleared");
    chk_done_wel: assert property ($fell(statusReg[0]) |-> !statusReg[1]) else $error("latch kept");
    chk_start_wel: assert property ($rose(statusReg[0]) |-> statusReg[1]) else $error("no latch");
    chk_fail_wel: assert property (
        $rose(flagStatus[4]) && !flagStatus[1] |-> ##[0:1] statusReg[1:0] == 2'h0) else $error("timeout latch");
    chk_lock_flags: assert property (
        $rose(flagStatus[1]) |-> flagStatus[4] && statusReg[1]) else $error("lock flags");
    chk_exit_cfg: assert property ($fell(xipActive) |-> vcrXipEnableN) else $error("cfg kept");
    chk_entry_armed: assert property (
        $rose(xipActive) |-> !$past(vcrXipEnableN) || basicXip || nvcrXipMode != 3'h7) else $error("unarmed");
    chk_soft_clean: assert property (
        softReset |-> ##[0:2] statusReg == 8'h00 && flagStatus == 8'h00) else $error("reset state");
endmodule
`default_nettype wire

// [dv/fox_host_model.sv]
/* host side of the serial link, extended protocol.
   frames are timed in ns; the link clock idles low between frames. */
`timescale 1ns/100ps
`default_nettype none
module fox_host_model (
    // link towards the device
    output logic csN,
    output logic sclk,
    output logic [3:0] dq
);
    initial {csN, sclk, dq} = 6'h2A; // deselected, clock low
    // n low bits of v, msb first; upper lines carry the inverse to expose misuse
    task automatic frame(input logic [71:0] v, input int n);
        #1.3 csN = 1'h0; // keeps every pin change off the core clock edges
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            dq = {{3{~v[i]}}, v[i]};
            #32 sclk = 1'h1;
            #32 sclk = 1'h0;
        end
        #40 csN = 1'h1;
        dq = ~dq; // released lines must not keep the last value
        #98.7; // deselect gap above ten core cycles
    endtask
endmodule
`default_nettype wire

// [dv/fox_flash_ctrl_tb.sv]
/* bench for fox_flash_ctrl: host model drives the link.
   straps fixed: extended protocol, no boot mode, pin reset on. */
`timescale 1ns/100ps
`default_nettype none
module fox_flash_ctrl_tb;
    import fox_pkg::*;
    logic clk, rst, rstPinN, arrayReady, csN, sclk, xipActive, vcrXipEnableN, otpLocked, wipSeen, readStart, basicXip;
    logic [23:0] readAddr, lastRead;
    logic [3:0] dqIn;
    logic [7:0] statusReg, flagStatus;
    int fail_count = 0;
    int checks_done = 0;
    // 5 ns core clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    fox_host_model fox_host_model_i (.csN, .sclk, .dq(dqIn));
    // small timeout keeps the stall case short
    fox_flash_ctrl #(.PROG_TIMEOUT_CYC(64)) fox_flash_ctrl_i (.clk, .rst, .ce(1'h1), .csN, .sclk, .dqIn,
        .rstPinN, .protocolSel(PROTO_EXT), .basicXip, .nvcrXipMode(3'h7), .resetPinEnable(1'h1),
        .arrayReady, .statusReg, .flagStatus, .xipActive, .vcrXipEnableN, .otpLocked, .softReset(),
        .readStart, .readAddr);
    // notes a busy program and the address of each array read request
    always @(posedge clk) if (statusReg[0] === 1'h1) wipSeen <= 1'h1;
    always @(posedge clk) if (readStart === 1'h1) lastRead <= readAddr;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tx(input logic [71:0] v, input int n);
        fox_host_model_i.frame(v, n);
    endtask
    // write enable, one-byte program, bounded wait while busy
    task automatic prog(input logic [71:0] v);
        tx(72'h06, 8);
        tx(v, 40);
        repeat (100) if (statusReg[0] !== 1'h0) @(posedge clk);
    endtask
    task automatic enter();
        tx({8'h81, 8'hF7}, 16);
        check("arm", {7'h0, vcrXipEnableN}, 8'h00);
        tx({8'h0B, 24'h100, 8'h7F}, 40);
        check("mode", {7'h0, xipActive}, 8'h01);
    endtask
    task automatic t_prog();
        tx({8'h42, 32'h5A}, 40);
        check("status", statusReg, 8'h00);
        prog({8'h42, 32'hA5});
        check("busy", {7'h0, wipSeen}, 8'h01);
        check("status", statusReg, 8'h00);
        tx(72'h06, 8);
        tx({8'h42, 28'h0}, 36);
        check("cut", {flagStatus[3:0], statusReg[3:0]}, 8'h02);
        @(posedge clk) arrayReady <= 1'h0;
        prog({8'h42, 32'hA5});
        check("timeout", {flagStatus[3:0], statusReg[3:0]}, 8'h00);
        check("fail", flagStatus, 8'h10);
        @(posedge clk) arrayReady <= 1'h1;
        tx(72'h50, 8);
        $display("program test done");
    endtask
    task automatic t_xip();
        enter();
        tx({24'h200, 8'h00}, 32);
        check("read", lastRead[15:8], 8'h02);
        tx({24'h200, 8'h80}, 32);
        check("exit", {6'h0, vcrXipEnableN, xipActive}, 8'h02);
        enter();
        tx(72'h1FFFFFF, 25);
        check("forced", {7'h0, xipActive}, 8'h00);
        @(posedge clk) basicXip <= 1'h1;
        tx({8'h0B, 24'h0, 8'h00}, 40);
        check("basic", {7'h0, xipActive}, 8'h01);
        @(posedge clk) {rstPinN, basicXip} <= 2'h0;
        repeat (20) @(posedge clk);
        rstPinN <= 1'h1;
        repeat (10) @(posedge clk);
        check("pin", {7'h0, xipActive}, 8'h00);
        tx(72'h06, 8);
        tx(72'h66, 8);
        tx(72'h99, 8);
        check("soft", statusReg, 8'h00);
        $display("mode test done");
    endtask
    task automatic t_lock();
        prog({8'h42, 24'h40, 8'h00});
        check("lock", {7'h0, otpLocked}, 8'h01);
        prog({8'h42, 32'h33});
        check("locked", {flagStatus[4:1], statusReg[3:0]}, 8'h92);
        $display("lock test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        {rst, rstPinN, arrayReady, wipSeen, basicXip} = 5'h1C;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        t_prog();
        t_xip();
        t_lock();
        tally_and_finish();
    end
    // watchdog: the frames need well under 200 us
    initial begin
        #300000;
        fail_count++;
        tally_and_finish();
    end
endmodule
bind fox_flash_ctrl fox_flash_ctrl_asserts fox_flash_ctrl_asserts_i (.clk, .rst, .basicXip, .nvcrXipMode,
    .statusReg, .flagStatus, .xipActive, .vcrXipEnableN, .otpLocked, .softReset);
`default_nettype wire
